// file: verilog/psp_policy_ctrl.sv
// type-c attach and pd source policy with power stage steering
// Summary of operation
// [RULE1] feedback drive steers sensed voltage to contract
// [RULE2] silent sink keeps plain 5 V until detach
// [RULE3] current used for ocp, cc limit, compensation
// [RULE4] pps status samples current with 10-bit converter
// [RULE5] pps status voltage read from rail channel
// [RULE6] divider option presents legacy signalling, 3 A
// [RULE7] data phy advertises charging port, 1.5 A; this controller has no data phy logic
// [RULE8] caps and replies sent without external processor
// [RULE9] legitimate attach turns load switch on
// [RULE10] attach starts at 5 V, 3 A pull-up
// [RULE11] caps sent on oriented cc line
// [RULE12] bad request: reject, wait, resend caps
// [RULE13] cc over-voltage: disable, switch off, discharge
// [RULE14] detach: switch off, 5 V target, rewait
`timescale 1ns/100ps
`include "psp_map.svh"
module psp_policy_ctrl #(
   parameter int DEB_CYC  = `PSP_T_DEB_US * `PSP_CLK_MHZ,
   parameter int RESP_CYC = `PSP_T_RESP_US * `PSP_CLK_MHZ,
   parameter int REJ_CYC  = `PSP_T_REJ_US * `PSP_CLK_MHZ
) (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // cc line comparators
   input  wire logic        cc1_rd_i,
   input  wire logic        cc2_rd_i,
   input  wire logic        cc1_ovp_i,
   input  wire logic        cc2_ovp_i,
   // options
   input  wire logic        div_emul_en_i,
   input  wire logic        cable_comp_en_i,
   input  wire logic        legacy_dp_dm_short_i,
   // pd message layer
   input  wire logic        rx_valid_i,
   input  wire logic [1:0]  rx_type_i,
   input  wire logic [2:0]  rx_obj_pos_i,
   input  wire logic [15:0] rx_current_ma_i,
   input  wire logic [15:0] rx_voltage_mv_i,
   input  wire logic        tx_done_i,
   input  wire logic        tx_acked_i,
   output logic             tx_valid_o,
   output logic [2:0]       tx_type_o,
   output logic [31:0]      tx_data_o,
   output logic             tx_on_cc2_o,
   // converter
   input  wire logic        adc_valid_i,
   input  wire logic [9:0]  adc_data_i,
   output logic             adc_start_o,
   output logic             adc_chan_o,
   // sensed quantities
   input  wire logic [15:0] vfb_mv_i,
   input  wire logic [15:0] isense_ma_i,
   // power path and cc
   output logic             load_switch_o,
   output logic             bus_discharge_o,
   output logic             cc_pullup_3a_o,
   output logic [1:0]       legacy_sig_o,
   output logic [9:0]       feedback_drive_output_o
);
   psp_fb_if fb ();

   psp_pkg::psp_state_e st_ff, nxt_st;
   logic [23:0] tmr_ff, nxt_tmr;
   logic [3:0]  caps_ff, nxt_caps;
   logic        pd_seen_ff, nxt_pd_seen;
   logic        cc2_ff, nxt_cc2;
   logic        pps_ff, nxt_pps;
   logic        contr_ff, nxt_contr;
   logic [15:0] tgt_ff, nxt_tgt;
   logic [15:0] ilim_ff, nxt_ilim;
   logic [15:0] req_mv_ff, nxt_req_mv;
   logic [15:0] req_ma_ff, nxt_req_ma;
   logic [9:0]  ibus_ff, nxt_ibus;
   logic [9:0]  vbus_ff, nxt_vbus;
   logic        txv_ff, nxt_txv;
   logic [2:0]  txt_ff, nxt_txt;
   logic        adcs_ff, nxt_adcs;
   logic        adcc_ff, nxt_adcc;
   logic        gate_ff, nxt_gate;
   logic        bus_discharge_pin_ff, nxt_bus_discharge_pin;
   logic        pull_ff, nxt_pull;
   logic [1:0]  leg_ff, nxt_leg;
   logic        ovp, rd_sel, req_good;

   // maximum current of an object position, zero for an unknown one
   function automatic logic [15:0] pos_ma(input logic [2:0] pos);
      if (pos == 3'h5 || pos == 3'h7) pos_ma = `PSP_PDO5_MA;
      else if (pos == 3'h0) pos_ma = 16'h0000;
      else pos_ma = `PSP_PDO_MA;
   endfunction

   // output voltage of an object position; programmable ones take the asked value
   function automatic logic [15:0] pos_mv(input logic [2:0] pos, input logic [15:0] ask);
      case (pos)
         3'h2:    pos_mv = `PSP_PDO2_MV;
         3'h3:    pos_mv = `PSP_PDO3_MV;
         3'h4:    pos_mv = `PSP_PDO4_MV;
         3'h5:    pos_mv = `PSP_PDO5_MV;
         3'h6,
         3'h7:    pos_mv = ask;
         default: pos_mv = `PSP_PDO1_MV;
      endcase
   endfunction

   // request check: known position, current in range, pps voltage in window
   function automatic logic check_req(input logic [2:0] pos, input logic [15:0] ma,
                                      input logic [15:0] mv);
      logic [15:0] vmax;
      vmax = (pos == 3'h6) ? `PSP_APDO1_MAX_MV : `PSP_APDO2_MAX_MV;
      check_req = (pos != 3'h0) && (pos <= `PSP_NUM_PDO) && (ma <= pos_ma(pos))
                  && (pos < 3'h6 || (mv >= `PSP_APDO_MIN_MV && mv <= vmax));
   endfunction

   assign ovp      = cc1_ovp_i | cc2_ovp_i;
   assign rd_sel   = cc2_ff ? cc2_rd_i : cc1_rd_i;
   assign req_good = check_req(rx_obj_pos_i, rx_current_ma_i, rx_voltage_mv_i);

   // policy state machine and its outputs
   always_comb begin
      nxt_st      = st_ff;
      nxt_tmr     = (tmr_ff != 24'h000000) ? tmr_ff - 24'h000001 : tmr_ff;
      nxt_caps    = caps_ff;
      nxt_pd_seen = pd_seen_ff;
      nxt_cc2     = cc2_ff;
      nxt_pps     = pps_ff;
      nxt_contr   = contr_ff;
      nxt_tgt     = tgt_ff;
      nxt_ilim    = ilim_ff;
      nxt_req_mv  = req_mv_ff;
      nxt_req_ma  = req_ma_ff;
      nxt_ibus    = ibus_ff;
      nxt_vbus    = vbus_ff;
      nxt_txv     = txv_ff;
      nxt_txt     = txt_ff;
      nxt_adcs    = 1'b0;
      nxt_adcc    = adcc_ff;
      nxt_gate    = gate_ff;
      nxt_bus_discharge_pin    = bus_discharge_pin_ff;
      nxt_pull    = 1'b1;
      nxt_leg     = leg_ff;
      case (st_ff)
         psp_pkg::S_DETACHED: begin
            nxt_gate = 1'b0;
            nxt_bus_discharge_pin = 1'b1;
            // exactly one rd means a sink; both means an accessory, not a sink
            if (cc1_rd_i ^ cc2_rd_i) begin
               nxt_cc2 = cc2_rd_i; // [RULE11]
               nxt_tmr = 24'(DEB_CYC - 1);
               nxt_st  = psp_pkg::S_DEBOUNCE;
            end
         end
         psp_pkg::S_DEBOUNCE: begin
            if (!(rd_sel && (cc1_rd_i ^ cc2_rd_i))) begin
               nxt_st = psp_pkg::S_DETACHED;
            end else if (tmr_ff == 24'h000000) begin
               nxt_gate    = 1'b1; // [RULE9]
               nxt_bus_discharge_pin    = 1'b0;
               nxt_tgt     = `PSP_VSAFE5_MV; // [RULE10]
               nxt_ilim    = `PSP_TYPEC_MA; // [RULE10]
               nxt_caps    = 4'h0;
               nxt_pd_seen = 1'b0;
               nxt_leg     = div_emul_en_i ? (legacy_dp_dm_short_i ? psp_pkg::LEG_SHORT
                                                : psp_pkg::LEG_DIVIDER) : psp_pkg::LEG_NONE; // [RULE6]
               nxt_st      = psp_pkg::S_SEND_CAPS;
            end
         end
         psp_pkg::S_SEND_CAPS: begin
            nxt_txv = 1'b1; // [RULE8]
            nxt_txt = psp_pkg::TX_CAPS; // [RULE11]
            if (txv_ff && tx_done_i) begin
               nxt_txv  = 1'b0;
               nxt_caps = caps_ff + 4'h1;
               nxt_tmr  = 24'(RESP_CYC - 1);
               if (tx_acked_i) begin
                  nxt_pd_seen = 1'b1;
                  nxt_st      = psp_pkg::S_WAIT_REQ;
               end else if (!pd_seen_ff && caps_ff + 4'h1 >= `PSP_CAPS_TRIES) begin
                  nxt_st = psp_pkg::S_TYPEC; // [RULE2]
               end else begin
                  nxt_st = psp_pkg::S_BACKOFF;
               end
            end
         end
         psp_pkg::S_BACKOFF: begin
            if (tmr_ff == 24'h000000) nxt_st = psp_pkg::S_SEND_CAPS; // [RULE12]
         end
         psp_pkg::S_WAIT_REQ, psp_pkg::S_CONTRACT: begin
            if (rx_valid_i && rx_type_i == psp_pkg::RX_REQUEST) begin
               nxt_req_mv = pos_mv(rx_obj_pos_i, rx_voltage_mv_i);
               nxt_req_ma = rx_current_ma_i;
               nxt_pps    = (rx_obj_pos_i >= 3'h6);
               nxt_st     = req_good ? psp_pkg::S_ACCEPT : psp_pkg::S_REJECT; // [RULE12]
            end else if (rx_valid_i && rx_type_i == psp_pkg::RX_GET_PPS && contr_ff
                         && pps_ff) begin
               nxt_adcs = 1'b1; // [RULE4]
               nxt_adcc = `PSP_ADC_CH_IBUS; // [RULE4]
               nxt_st   = psp_pkg::S_PPS_IBUS;
            end else if (st_ff == psp_pkg::S_WAIT_REQ && tmr_ff == 24'h000000) begin
               nxt_st = psp_pkg::S_SEND_CAPS;
            end
         end
         psp_pkg::S_REJECT: begin
            nxt_txv = 1'b1;
            nxt_txt = psp_pkg::TX_REJECT; // [RULE12]
            if (txv_ff && tx_done_i) begin
               nxt_txv = 1'b0;
               nxt_tmr = 24'(REJ_CYC - 1);
               nxt_st  = psp_pkg::S_BACKOFF; // [RULE12]
            end
         end
         psp_pkg::S_ACCEPT: begin
            nxt_txv = 1'b1;
            nxt_txt = psp_pkg::TX_ACCEPT;
            if (txv_ff && tx_done_i) begin
               nxt_txv   = 1'b0;
               nxt_tgt   = req_mv_ff; // [RULE1]
               nxt_ilim  = req_ma_ff;
               nxt_contr = 1'b1;
               nxt_tmr   = 24'(RESP_CYC - 1);
               nxt_st    = psp_pkg::S_SETTLE;
            end
         end
         psp_pkg::S_SETTLE: begin
            // settle flag lags one clock; its stale value from the old target can end the settle at once
            if (fb.settled || tmr_ff == 24'h000000) nxt_st = psp_pkg::S_PS_RDY;
         end
         psp_pkg::S_PS_RDY: begin
            nxt_txv = 1'b1;
            nxt_txt = psp_pkg::TX_PS_RDY;
            if (txv_ff && tx_done_i) begin
               nxt_txv = 1'b0;
               nxt_st  = psp_pkg::S_CONTRACT;
            end
         end
         psp_pkg::S_PPS_IBUS: begin
            if (adc_valid_i) begin
               nxt_ibus = adc_data_i; // [RULE4]
               nxt_adcs = 1'b1;
               nxt_adcc = `PSP_ADC_CH_VBUS; // [RULE5]
               nxt_st   = psp_pkg::S_PPS_VBUS;
            end
         end
         psp_pkg::S_PPS_VBUS: begin
            if (adc_valid_i) begin
               nxt_vbus = adc_data_i; // [RULE5]
               nxt_st   = psp_pkg::S_PPS_TX;
            end
         end
         psp_pkg::S_PPS_TX: begin
            nxt_txv = 1'b1;
            nxt_txt = psp_pkg::TX_PPS_ST; // [RULE4]
            if (txv_ff && tx_done_i) begin
               nxt_txv = 1'b0;
               nxt_st  = psp_pkg::S_CONTRACT;
            end
         end
         psp_pkg::S_TYPEC: begin
            nxt_tgt = `PSP_VSAFE5_MV; // [RULE2]
         end
         default: begin
            nxt_gate = 1'b0;
            nxt_bus_discharge_pin = 1'b1;
            nxt_pull = 1'b0;
            if (!ovp && !cc1_rd_i && !cc2_rd_i) nxt_st = psp_pkg::S_DETACHED;
         end
      endcase
      // detach or fault drops power and contract; faults outrank detach
      if (ovp || fb.ocp_trip || (st_ff != psp_pkg::S_DETACHED && st_ff != psp_pkg::S_DEBOUNCE
          && st_ff != psp_pkg::S_DISABLED && !rd_sel)) begin
         nxt_st    = (ovp || fb.ocp_trip) ? psp_pkg::S_DISABLED : psp_pkg::S_DETACHED; // [RULE13]
         nxt_gate  = 1'b0; // [RULE14]
         nxt_bus_discharge_pin  = 1'b1; // [RULE13]
         nxt_pull  = !(ovp || fb.ocp_trip);
         nxt_tgt   = `PSP_VSAFE5_MV; // [RULE14]
         nxt_ilim  = `PSP_TYPEC_MA;
         nxt_contr = 1'b0;
         nxt_pps   = 1'b0;
         nxt_txv   = 1'b0;
         nxt_leg   = psp_pkg::LEG_NONE;
      end
   end

   // register stage; reset leaves the bus discharged and unpowered
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         st_ff      <= psp_pkg::S_DETACHED;
         tmr_ff     <= 24'h000000;
         caps_ff    <= 4'h0;
         pd_seen_ff <= 1'b0;
         cc2_ff     <= 1'b0;
         pps_ff     <= 1'b0;
         contr_ff   <= 1'b0;
         tgt_ff     <= `PSP_VSAFE5_MV;
         ilim_ff    <= `PSP_TYPEC_MA;
         req_mv_ff  <= `PSP_VSAFE5_MV;
         req_ma_ff  <= 16'h0000;
         ibus_ff    <= 10'h000;
         vbus_ff    <= 10'h000;
         txv_ff     <= 1'b0;
         txt_ff     <= psp_pkg::TX_CAPS;
         adcs_ff    <= 1'b0;
         adcc_ff    <= `PSP_ADC_CH_IBUS;
         gate_ff    <= 1'b0;
         bus_discharge_pin_ff    <= 1'b1;
         pull_ff    <= 1'b1;
         leg_ff     <= psp_pkg::LEG_NONE;
      end else begin
         st_ff      <= nxt_st;
         tmr_ff     <= nxt_tmr;
         caps_ff    <= nxt_caps;
         pd_seen_ff <= nxt_pd_seen;
         cc2_ff     <= nxt_cc2;
         pps_ff     <= nxt_pps;
         contr_ff   <= nxt_contr;
         tgt_ff     <= nxt_tgt;
         ilim_ff    <= nxt_ilim;
         req_mv_ff  <= nxt_req_mv;
         req_ma_ff  <= nxt_req_ma;
         ibus_ff    <= nxt_ibus;
         vbus_ff    <= nxt_vbus;
         txv_ff     <= nxt_txv;
         txt_ff     <= nxt_txt;
         adcs_ff    <= nxt_adcs;
         adcc_ff    <= nxt_adcc;
         gate_ff    <= nxt_gate;
         bus_discharge_pin_ff    <= nxt_bus_discharge_pin;
         pull_ff    <= nxt_pull;
         leg_ff     <= nxt_leg;
      end
   end

   // loop targets
   assign fb.target_mv  = tgt_ff;
   assign fb.ilim_ma    = ilim_ff;
   assign fb.pps_mode   = contr_ff & pps_ff;
   assign fb.fixed_mode = contr_ff & ~pps_ff;
   assign fb.cable_comp = cable_comp_en_i;

   psp_fb_loop u_loop (
      .core_clk_i       (core_clk_i),
      .rst_n_i          (rst_n_i),
      .vfb_mv_i         (vfb_mv_i),
      .isense_ma_i      (isense_ma_i),
      .fb               (fb.loop),
      .feedback_drive_o (feedback_drive_output_o)
   );

   // registered outputs
   assign tx_valid_o      = txv_ff;
   assign tx_type_o       = txt_ff;
   assign tx_data_o       = {6'h00, vbus_ff, 6'h00, ibus_ff};
   assign tx_on_cc2_o     = cc2_ff; // [RULE11]
   assign adc_start_o     = adcs_ff;
   assign adc_chan_o      = adcc_ff;
   assign load_switch_o   = gate_ff;
   assign bus_discharge_o = bus_discharge_pin_ff;
   assign cc_pullup_3a_o  = pull_ff;
   assign legacy_sig_o    = leg_ff;
endmodule // psp_policy_ctrl

// file: verilog/psp_map.svh
// offsets-free constant map: timing, limits and source capability table
`ifndef PSP_MAP_SVH
`define PSP_MAP_SVH
`define PSP_CLK_MHZ        125
`define PSP_T_DEB_US       100
`define PSP_T_RESP_US      30000
`define PSP_T_REJ_US       5000
`define PSP_CAPS_TRIES     4'h8
`define PSP_FB_DIV         8'h7C
`define PSP_FB_RST         10'h200
`define PSP_FB_TOL_MV      16'h0064
`define PSP_OCP_MARGIN_MA  16'h00FA
`define PSP_OCP_TICKS      8'h10
`define PSP_VSAFE5_MV      16'h1388
`define PSP_TYPEC_MA       16'h0BB8
`define PSP_NUM_PDO        3'h7
`define PSP_PDO1_MV        16'h1388
`define PSP_PDO2_MV        16'h2328
`define PSP_PDO3_MV        16'h2EE0
`define PSP_PDO4_MV        16'h3A98
`define PSP_PDO5_MV        16'h4E20
`define PSP_PDO_MA         16'h0BB8
`define PSP_PDO5_MA        16'h08CA
`define PSP_APDO_MIN_MV    16'h0CE4
`define PSP_APDO1_MAX_MV   16'h3E80
`define PSP_APDO2_MAX_MV   16'h5208
`define PSP_ADC_CH_IBUS    1'b0
`define PSP_ADC_CH_VBUS    1'b1
`endif

// file: verilog/psp_pkg.sv
// shared types of the source policy controller
package psp_pkg;
   typedef enum logic [3:0] {
      S_DETACHED  = 4'h0,
      S_DEBOUNCE  = 4'h1,
      S_SEND_CAPS = 4'h2,
      S_BACKOFF   = 4'h3,
      S_WAIT_REQ  = 4'h4,
      S_REJECT    = 4'h5,
      S_ACCEPT    = 4'h6,
      S_SETTLE    = 4'h7,
      S_PS_RDY    = 4'h8,
      S_CONTRACT  = 4'h9,
      S_PPS_IBUS  = 4'hA,
      S_PPS_VBUS  = 4'hB,
      S_PPS_TX    = 4'hC,
      S_TYPEC     = 4'hD,
      S_DISABLED  = 4'hE
   } psp_state_e;
   typedef enum logic [1:0] {
      RX_REQUEST = 2'h0,
      RX_GET_PPS = 2'h1,
      RX_OTHER   = 2'h2
   } psp_rx_e;
   typedef enum logic [2:0] {
      TX_CAPS   = 3'h0,
      TX_ACCEPT = 3'h1,
      TX_REJECT = 3'h2,
      TX_PS_RDY = 3'h3,
      TX_PPS_ST = 3'h4
   } psp_tx_e;
   typedef enum logic [1:0] {
      LEG_NONE    = 2'h0,
      LEG_SHORT   = 2'h1,
      LEG_DIVIDER = 2'h2
   } psp_leg_e;
endpackage

// file: verilog/psp_fb_if.sv
// policy-to-loop carrier: targets down, loop status up
`timescale 1ns/100ps
interface psp_fb_if;
   logic [15:0] target_mv;
   logic [15:0] ilim_ma;
   logic        pps_mode;
   logic        fixed_mode;
   logic        cable_comp;
   logic        ocp_trip;
   logic        settled;
   modport ctrl (output target_mv, ilim_ma, pps_mode, fixed_mode, cable_comp,
                 input ocp_trip, settled);
   modport loop (input target_mv, ilim_ma, pps_mode, fixed_mode, cable_comp,
                 output ocp_trip, settled);
endinterface

// file: verilog/psp_fb_loop.sv
// feedback drive stepping loop with current limit and over-current check
`timescale 1ns/100ps
`include "psp_map.svh"
module psp_fb_loop (
   // clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   // sensed quantities
   input  wire logic [15:0] vfb_mv_i,
   input  wire logic [15:0] isense_ma_i,
   // policy side
   psp_fb_if.loop          fb,
   // power stage drive
   output logic [9:0]       feedback_drive_o
);
   logic [7:0]  div_ff, nxt_div;
   logic [7:0]  ocp_cnt_ff, nxt_ocp_cnt;
   logic [9:0]  drv_ff, nxt_drv;
   logic        trip_ff, nxt_trip;
   logic        set_ff, nxt_set;
   logic [15:0] tgt;
   logic        tick;

   // slow tick: stepping every clock would ring the stage filter
   assign tick = (div_ff == 8'h00);
   // cable drop: roughly 62 mohm worth of lift per sensed mA
   assign tgt = fb.target_mv + (fb.cable_comp ? (isense_ma_i >> 4) : 16'h0000); // [RULE3]

   // next drive, settle and trip values
   always_comb begin
      nxt_div     = tick ? `PSP_FB_DIV : div_ff - 8'h01;
      nxt_drv     = drv_ff;
      nxt_ocp_cnt = ocp_cnt_ff;
      nxt_trip    = 1'b0;
      nxt_set     = ((vfb_mv_i > tgt) ? vfb_mv_i - tgt : tgt - vfb_mv_i) <= `PSP_FB_TOL_MV;
      if (tick) begin
         if (fb.pps_mode && isense_ma_i > fb.ilim_ma) begin
            if (drv_ff != 10'h000) nxt_drv = drv_ff - 10'h001; // [RULE3]
         end else if (vfb_mv_i < tgt) begin
            if (drv_ff != 10'h3FF) nxt_drv = drv_ff + 10'h001; // [RULE1]
         end else if (vfb_mv_i > tgt) begin
            if (drv_ff != 10'h000) nxt_drv = drv_ff - 10'h001; // [RULE1]
         end
         if (fb.fixed_mode && isense_ma_i > fb.ilim_ma + `PSP_OCP_MARGIN_MA) begin
            nxt_ocp_cnt = ocp_cnt_ff + 8'h01;
            if (ocp_cnt_ff == `PSP_OCP_TICKS) begin
               nxt_trip    = 1'b1; // [RULE3]
               nxt_ocp_cnt = 8'h00;
            end
         end else begin
            nxt_ocp_cnt = 8'h00;
         end
      end
   end

   // register stage
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         div_ff     <= 8'h00;
         drv_ff     <= `PSP_FB_RST;
         ocp_cnt_ff <= 8'h00;
         trip_ff    <= 1'b0;
         set_ff     <= 1'b0;
      end else begin
         div_ff     <= nxt_div;
         drv_ff     <= nxt_drv;
         ocp_cnt_ff <= nxt_ocp_cnt;
         trip_ff    <= nxt_trip;
         set_ff     <= nxt_set;
      end
   end

   assign fb.ocp_trip       = trip_ff;
   assign fb.settled        = set_ff;
   assign feedback_drive_o  = drv_ff;
endmodule // psp_fb_loop

// file: test/psp_sink_model.sv
// sink-side message layer model: finishes each send, acks on command
`timescale 1ns/100ps
module psp_sink_model (
   // clock
   input  wire logic core_clk_i,
   // source message request
   input  wire logic tx_valid_i,
   // scenario controls
   input  wire logic ack_en_i,
   input  wire logic slow_i,
   // completion back to the source
   output logic      tx_done_o,
   output logic      tx_acked_o
);
   logic [3:0] cnt_ff = 4'h0;
   initial tx_done_o = 1'h0;
   initial tx_acked_o = 1'h0;
   // ack toggles between sends: a stale value is no ack
   always @(posedge core_clk_i) begin
      tx_done_o <= 1'h0;
      tx_acked_o <= ~tx_acked_o;
      if (tx_valid_i && !tx_done_o) begin
         cnt_ff <= cnt_ff + 4'h1;
         if (cnt_ff == (slow_i ? 4'h9 : 4'h2)) begin
            tx_done_o <= 1'h1;
            tx_acked_o <= ack_en_i;
            cnt_ff <= 4'h0;
         end
      end
   end
endmodule // psp_sink_model

// file: test/psp_policy_ctrl_sva.sv
// port-level checks of the source policy controller
`timescale 1ns/100ps
module psp_policy_ctrl_sva (
   input wire logic       core_clk_i,
   input wire logic       rst_n_i,
   input wire logic       cc1_rd_i,
   input wire logic       cc2_rd_i,
   input wire logic       cc1_ovp_i,
   input wire logic       cc2_ovp_i,
   input wire logic       tx_done_i,
   input wire logic       tx_valid_o,
   input wire logic [2:0] tx_type_o,
   input wire logic       tx_on_cc2_o,
   input wire logic       load_switch_o,
   input wire logic       bus_discharge_o,
   input wire logic       cc_pullup_3a_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // reset keeps the bus dead and discharged
   a_reset_safe: assert property (disable iff (1'h0) !rst_n_i |=>
      !load_switch_o && bus_discharge_o && !tx_valid_o) else $error("bus live in reset");
   a_ovp_disable: assert property ((cc1_ovp_i || cc2_ovp_i) |=>
      !load_switch_o && bus_discharge_o && !cc_pullup_3a_o) else $error("cc ovp ignored");
   a_detach_off: assert property (load_switch_o && !cc1_rd_i && !cc2_rd_i |=>
      !load_switch_o) else $error("switch on after detach");
   a_attach_rd: assert property ($rose(load_switch_o) |-> (cc1_rd_i ^ cc2_rd_i)
      && $past(cc1_rd_i ^ cc2_rd_i, 8)) else $error("switch on without held rd");
   a_attach_pullup: assert property ($rose(load_switch_o) |->
      cc_pullup_3a_o && !bus_discharge_o) else $error("attach without 3a pullup");
   a_caps_first: assert property ($rose(load_switch_o) |=>
      tx_valid_o && tx_type_o == 3'h0) else $error("caps not sent after attach");
   a_cc_orient: assert property (tx_valid_o && load_switch_o && (cc1_rd_i ^ cc2_rd_i) |->
      tx_on_cc2_o == cc2_rd_i) else $error("message on wrong cc line");
   a_tx_hold: assert property (tx_valid_o && !tx_done_i && load_switch_o &&
      !cc1_ovp_i && !cc2_ovp_i && (cc1_rd_i ^ cc2_rd_i) |=> tx_valid_o && $stable(tx_type_o))
      else $error("message dropped before done");
   a_tx_release: assert property (tx_valid_o && tx_done_i |=> !tx_valid_o)
      else $error("message held after done");
endmodule // psp_policy_ctrl_sva

// file: test/psp_policy_ctrl_bench.sv
// self-checking bench of the source policy controller with a sink model
`timescale 1ns/100ps
module psp_policy_ctrl_bench;
   localparam int DEB = 20;
   logic core_clk_i = 1'h0, rst_n_i = 1'h0, cc1_rd_i = 1'h0, cc2_rd_i = 1'h0;
   logic cc1_ovp_i = 1'h0, cc2_ovp_i = 1'h0, div_emul_en_i = 1'h0, cable_comp_en_i = 1'h0;
   logic legacy_dp_dm_short_i = 1'h0, rx_valid_i = 1'h0, adc_valid_i = 1'h0;
   logic ack_en = 1'h1, slow = 1'h0, o2;
   logic [1:0]  rx_type_i = 2'h0;
   logic [2:0]  rx_obj_pos_i = 3'h0, ty;
   logic [15:0] rx_current_ma_i = 16'h0, rx_voltage_mv_i = 16'h0;
   logic [15:0] vfb_mv_i = 16'h1388, isense_ma_i = 16'h0;
   logic [9:0]  adc_data_i = 10'h0, feedback_drive_output_o;
   logic        tx_done_i, tx_acked_i, tx_valid_o, tx_on_cc2_o, adc_start_o, adc_chan_o;
   logic        load_switch_o, bus_discharge_o, cc_pullup_3a_o;
   logic [2:0]  tx_type_o;
   logic [31:0] tx_data_o, dat;
   logic [1:0]  legacy_sig_o;
   int          num_errors = 0, n_tests = 0;
   psp_policy_ctrl #(.DEB_CYC(DEB), .RESP_CYC(200), .REJ_CYC(50)) uut (.core_clk_i, .rst_n_i,
      .cc1_rd_i, .cc2_rd_i, .cc1_ovp_i, .cc2_ovp_i, .div_emul_en_i, .cable_comp_en_i,
      .legacy_dp_dm_short_i, .rx_valid_i, .rx_type_i, .rx_obj_pos_i, .rx_current_ma_i,
      .rx_voltage_mv_i, .tx_done_i, .tx_acked_i, .tx_valid_o, .tx_type_o, .tx_data_o,
      .tx_on_cc2_o, .adc_valid_i, .adc_data_i, .adc_start_o, .adc_chan_o, .vfb_mv_i,
      .isense_ma_i, .load_switch_o, .bus_discharge_o, .cc_pullup_3a_o, .legacy_sig_o,
      .feedback_drive_output_o);
   psp_sink_model u_sink (.core_clk_i, .tx_valid_i(tx_valid_o), .ack_en_i(ack_en),
      .slow_i(slow), .tx_done_o(tx_done_i), .tx_acked_o(tx_acked_i));
   // 125 MHz core clock
   always #4 core_clk_i = ~core_clk_i;
   // inputs move 1 ns after the edge so sampling never races
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("errors %0d compares %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // next outgoing message, held until the sink model completes it
   task automatic wait_tx();
      int k;
      for (k = 0; k < 3000 && !tx_valid_o; k++) cyc(1);
      ty = tx_valid_o ? tx_type_o : 3'h7;
      dat = tx_data_o;
      o2 = tx_on_cc2_o;
      for (k = 0; k < 50 && tx_valid_o; k++) cyc(1);
   endtask
   task automatic rx(input logic [1:0] t, input logic [2:0] p, input logic [15:0] ma,
                     input logic [15:0] mv);
      rx_type_i = t;
      rx_obj_pos_i = p;
      rx_current_ma_i = ma;
      rx_voltage_mv_i = mv;
      rx_valid_i = 1'h1;
      cyc(1);
      rx_valid_i = 1'h0;
   endtask
   task automatic adc(input logic ch, input logic [9:0] v);
      int k;
      for (k = 0; k < 50 && !adc_start_o; k++) cyc(1);
      chk(adc_chan_o, ch);
      cyc(3);
      adc_data_i = v;
      adc_valid_i = 1'h1;
      cyc(1);
      adc_valid_i = 1'h0;
      adc_data_i = ~v;
   endtask
   task automatic attach(input logic o, input logic d, input logic s);
      int k;
      div_emul_en_i = d;
      legacy_dp_dm_short_i = s;
      cc1_rd_i = !o;
      cc2_rd_i = o;
      for (k = 0; k < 200 && !load_switch_o; k++) cyc(1);
      chk(k >= DEB && k <= DEB + 3, 1);
      chk({bus_discharge_o, cc_pullup_3a_o}, 2'h1);
      wait_tx();
      chk({ty, o2}, {3'h0, o});
      chk(legacy_sig_o, d ? (s ? 2'h1 : 2'h2) : 2'h0);
   endtask
   task automatic detach();
      cc1_rd_i = 1'h0;
      cc2_rd_i = 1'h0;
      cyc(3);
      chk({load_switch_o, bus_discharge_o}, 2'h1);
   endtask
   // bad position, then over-limit current: both refused and re-advertised
   task automatic t_reject();
      rx(2'h0, 3'h0, 16'h03E8, 16'h0);
      wait_tx();
      chk(ty, 3'h2);
      wait_tx();
      chk(ty, 3'h0);
      rx(2'h0, 3'h1, 16'h0C1C, 16'h0);
      wait_tx();
      chk(ty, 3'h2);
      wait_tx();
      chk(ty, 3'h0);
   endtask
   // 9 V contract: drive follows the target, then over-current trips
   task automatic t_fixed();
      logic [9:0] d0;
      rx(2'h0, 3'h2, 16'h07D0, 16'h0);
      wait_tx();
      chk(ty, 3'h1);
      wait_tx();
      chk(ty, 3'h3);
      d0 = feedback_drive_output_o;
      cyc(1000);
      chk(feedback_drive_output_o > d0, 1);
      vfb_mv_i = 16'h2EE0;
      d0 = feedback_drive_output_o;
      cyc(1000);
      chk(feedback_drive_output_o < d0, 1);
      isense_ma_i = 16'h0CE4;
      cyc(2600);
      chk({load_switch_o, cc_pullup_3a_o, bus_discharge_o}, 3'h1);
      isense_ma_i = 16'h0;
   endtask
   // pps contract and status request, slow acks
   task automatic t_pps();
      rx(2'h0, 3'h6, 16'h03E8, 16'h1388);
      wait_tx();
      chk(ty, 3'h1);
      wait_tx();
      chk(ty, 3'h3);
      rx(2'h1, 3'h0, 16'h0, 16'h0);
      adc(1'h0, 10'h155);
      adc(1'h1, 10'h2AA);
      wait_tx();
      chk({ty, dat}, {3'h4, 6'h0, 10'h2AA, 6'h0, 10'h155});
   endtask
   task automatic t_ovp();
      cc2_ovp_i = 1'h1;
      cyc(2);
      chk({load_switch_o, bus_discharge_o, cc_pullup_3a_o}, 3'h2);
      cc2_ovp_i = 1'h0;
   endtask
   // silent sink: tries run out, 5 V stays, traffic stops
   task automatic t_silent();
      int k, n;
      cyc(2500);
      n = 0;
      for (k = 0; k < 600; k++) begin
         cyc(1);
         n += tx_valid_o;
      end
      chk({load_switch_o, n[7:0]}, 9'h100);
   endtask
   // main sequence
   initial begin
      cyc(8);
      rst_n_i = 1'h1;
      chk({load_switch_o, bus_discharge_o, cc_pullup_3a_o, tx_valid_o, feedback_drive_output_o},
          {4'h6, 10'h200});
      attach(1'h0, 1'h0, 1'h0);
      t_reject();
      t_fixed();
      detach();
      vfb_mv_i = 16'h1388;
      slow = 1'h1;
      attach(1'h1, 1'h1, 1'h0);
      t_pps();
      t_ovp();
      detach();
      slow = 1'h0;
      ack_en = 1'h0;
      attach(1'h0, 1'h0, 1'h1);
      t_silent();
      detach();
      wrap_up();
   end
   // watchdog well beyond the expected run length
   initial begin
      cyc(40000);
      num_errors++;
      wrap_up();
   end
endmodule // psp_policy_ctrl_bench
bind psp_policy_ctrl psp_policy_ctrl_sva u_sva (.core_clk_i, .rst_n_i, .cc1_rd_i, .cc2_rd_i,
   .cc1_ovp_i, .cc2_ovp_i, .tx_done_i, .tx_valid_o, .tx_type_o, .tx_on_cc2_o, .load_switch_o,
   .bus_discharge_o, .cc_pullup_3a_o);
